// File: common/adcc_pkg.sv
// Constants, register map and types for the converter control block.
// Assumes one 125 MHz core clock; one core clock period stands for one oscillator period.
//
// Notes on behaviour
// [RULE1] Pin config register bits 7..3 read zero and ignore writes.
// [RULE2] Codes 001/011/101 take external reference; 100/101 pins 2,5 digital; 11x all digital.
// [RULE3] Completion loads result, clears conversion-active bit, sets done flag.
// [RULE4] Result register has no reset; contents undefined after power-on.
// [RULE5] Software waits two bit periods after completion before next acquisition.
// [RULE6] Software waits the acquisition time after a channel change before starting.
// [RULE7] Holding capacitor is disconnected from the input when conversion starts.
// [RULE8] One 8-bit conversion takes nine and a half bit periods.
// [RULE9] Clock select: 00 two, 01 eight, 10 thirty-two oscillator periods, 11 RC.
// [RULE10] Software picks a clock giving at least the minimum bit period.
// [RULE11] Software selects RC clock before sleep to convert during sleep.
// [RULE12] RC clock source gives a typical four microsecond bit period.
// [RULE13] Port data reads return zero on pins configured analog.
// [RULE14] Conversion runs regardless of channel select and pin direction.
// [RULE15] Software should not set the active bit in the write turning converter on.
// [RULE16] Trigger with matching compare mode and converter on starts conversion, clears timer.
// [RULE17] Trigger with converter off starts nothing but still clears timer.
// [RULE18] Software clears flag, enables interrupt, then starts; clears flag after reading.
// [RULE19] Writing one to active bit while on starts; bit reads one until done.
// [RULE20] Channel select codes 000..100 pick input channels zero to four.
// [RULE21] Reset restores registers, turns converter off, aborts any conversion.
// [RULE22] One result bit per bit period, MSB first; last half period completes.
package adcc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_RESULT    = 8'h1e;
  localparam logic [7:0] OFF_CONTROL   = 8'h1f;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h8c;
  localparam logic [7:0] OFF_PIN_CFG   = 8'h9f;
  localparam logic [7:0] OFF_PORT_DATA = 8'h05;
  localparam logic [7:0] OFF_PORT_DIR  = 8'h85;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned CTL_ON_BIT    = 0;
  localparam int unsigned CTL_GO_BIT    = 2;
  localparam int unsigned CTL_CHS_LSB   = 3;
  localparam int unsigned CTL_CS_LSB    = 6;
  localparam int unsigned IRQ_DONE_BIT  = 6;
  localparam int unsigned PIN_CFG_W     = 3;
  localparam int unsigned PORT_W        = 6;
  localparam int unsigned CHAN_N        = 5;
  localparam logic [1:0]  CS_RST        = 2'h0;
  localparam logic [2:0]  CHS_RST       = 3'h0;
  localparam logic [2:0]  PIN_CFG_RST   = 3'h0;
  localparam logic [5:0]  PORT_DIR_RST  = 6'h3f;
  localparam logic [5:0]  ANA_MASK_ALL  = 6'h2f;
  localparam logic [5:0]  ANA_MASK_PART = 6'h0b;
  localparam logic [5:0]  ANA_MASK_NONE = 6'h00;
  localparam logic [1:0]  PIN_CFG_DIG   = 2'h3;
  localparam int unsigned CHAN4_PIN     = 5;

  // ****************************************
  // Clock select and trigger codes
  // ****************************************
  localparam logic [1:0] CS_OSC2  = 2'h0;
  localparam logic [1:0] CS_OSC8  = 2'h1;
  localparam logic [1:0] CS_OSC32 = 2'h2;
  localparam logic [3:0] CMP_MODE_TRIG = 4'hb;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned RC_BIT_PERIOD_NS = 4000;
  localparam int unsigned HALF_W           = 9;
  localparam logic [8:0]  HALF_OSC2  = 9'h001;
  localparam logic [8:0]  HALF_OSC8  = 9'h004;
  localparam logic [8:0]  HALF_OSC32 = 9'h010;
  localparam logic [8:0]  HALF_RC    = 9'(RC_BIT_PERIOD_NS / 2 / CLK_PERIOD_NS);
  localparam logic [4:0]  CONV_HALVES = 5'h13;
  localparam logic [4:0]  LAST_HALF   = 5'h12;
  localparam logic [4:0]  FIRST_DECIDE = 5'h03;
  localparam logic [3:0]  RES_BITS    = 4'h8;
  localparam logic [7:0]  MSB_MASK    = 8'h80;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_t;

endpackage : adcc_pkg

// File: logic/adcc_half_tick.sv
// Half bit period divider: one-cycle tick every load cycles while running.
// Assumes the load value is held stable while run is high.
`timescale 1ns/1ps
module adcc_half_tick (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       restart_i,
  input  wire logic       run_i,
  input  wire logic [8:0] load_i,
  output logic            tick_o
);

  logic [8:0] cnt_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 9'h000;
    end else if (restart_i) begin
      cnt_r <= load_i - 9'h001;
    end else if (run_i) begin
      if (cnt_r == 9'h000) begin
        cnt_r <= load_i - 9'h001;
      end else begin
        cnt_r <= cnt_r - 9'h001;
      end
    end
  end

  assign tick_o = run_i && !restart_i && (cnt_r == 9'h000);

endmodule : adcc_half_tick

// File: logic/adcc_top.sv
// Converter control: registers, pin decode, conversion clock and SAR sequencing.
// Assumes an analog comparator and hold stage outside; port pins are asynchronous.
// Assumes the comparator settles within one clock of a trial code change.
`timescale 1ns/1ps
module adcc_top (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       comp_hi_i,
  input  wire logic [5:0] pin_level_i,
  input  wire logic [3:0] compare_mode_sel_i,
  input  wire logic       special_trig_i,
  output logic            conv_done_irq_o,
  output logic            timer_clear_o,
  output logic            sample_connect_o,
  output logic      [4:0] chan_onehot_o,
  output logic            vref_ext_o,
  output logic      [5:0] analog_pins_o,
  output logic      [7:0] trial_code_o,
  output logic            converter_on_o
);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic rst_meta_r;
  logic rst_n;
  logic comp_sync_r;
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Comparator answers our own trial code; one flop keeps a two-cycle bit period
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      comp_sync_r <= 1'b0;
      pin_meta_r  <= 6'h00;
      pin_sync_r  <= 6'h00;
    end else begin
      comp_sync_r <= comp_hi_i;
      pin_meta_r  <= pin_level_i;
      pin_sync_r  <= pin_meta_r;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  adcc_pkg::adcc_state_t state_r;
  logic [1:0] cs_r;
  logic [2:0] chs_r;
  logic       on_r;
  logic       go_r;
  logic [2:0] pin_cfg_r;
  logic [5:0] port_dir_r;
  logic       flag_r;
  logic       irq_en_r;
  logic [7:0] result_r;
  logic [7:0] trial_r;
  logic [7:0] mask_r;
  logic [4:0] half_cnt_r;
  logic [8:0] load_r;
  logic [8:0] load_nxt;
  logic       tick;
  logic       wr_ctl;
  logic       wr_start;
  logic       trig_hit;
  logic       start;
  logic       decide;
  logic       done;
  logic       abort;
  logic [7:0] trial_nxt;

  assign wr_ctl   = wr_i && (addr_i == adcc_pkg::OFF_CONTROL);
  assign trig_hit = special_trig_i && (compare_mode_sel_i == adcc_pkg::CMP_MODE_TRIG);
  assign wr_start = wr_ctl && wdata_i[adcc_pkg::CTL_GO_BIT] && wdata_i[adcc_pkg::CTL_ON_BIT]
                    && on_r; // RULE19
  assign start    = (state_r == adcc_pkg::ADCC_IDLE) && (wr_start || (trig_hit && on_r)); // RULE16
  assign abort    = wr_ctl && !wdata_i[adcc_pkg::CTL_ON_BIT];
  assign decide   = (state_r == adcc_pkg::ADCC_CONV) && tick && half_cnt_r[0]
                    && (half_cnt_r >= adcc_pkg::FIRST_DECIDE);
  assign done     = (state_r == adcc_pkg::ADCC_CONV) && tick
                    && (half_cnt_r == adcc_pkg::LAST_HALF) && !abort;

  // ****************************************
  // Conversion clock select
  // ****************************************
  always_comb begin
    if (cs_r == adcc_pkg::CS_OSC2) begin // RULE9
      load_nxt = adcc_pkg::HALF_OSC2;
    end else if (cs_r == adcc_pkg::CS_OSC8) begin
      load_nxt = adcc_pkg::HALF_OSC8;
    end else if (cs_r == adcc_pkg::CS_OSC32) begin
      load_nxt = adcc_pkg::HALF_OSC32;
    end else begin
      load_nxt = adcc_pkg::HALF_RC; // RULE12
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= adcc_pkg::HALF_OSC2;
    end else if (start) begin
      load_r <= load_nxt;
    end
  end

  adcc_half_tick u_half_tick (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .restart_i (start),
    .run_i     (state_r == adcc_pkg::ADCC_CONV),
    .load_i    (start ? load_nxt : load_r),
    .tick_o    (tick)
  );

  // ****************************************
  // Control and configuration registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin // RULE21
      cs_r  <= adcc_pkg::CS_RST;
      chs_r <= adcc_pkg::CHS_RST;
      on_r  <= 1'b0;
    end else if (wr_ctl) begin
      cs_r  <= wdata_i[adcc_pkg::CTL_CS_LSB +: 2];
      chs_r <= wdata_i[adcc_pkg::CTL_CHS_LSB +: 3];
      on_r  <= wdata_i[adcc_pkg::CTL_ON_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_cfg_r  <= adcc_pkg::PIN_CFG_RST;
      port_dir_r <= adcc_pkg::PORT_DIR_RST;
      irq_en_r   <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == adcc_pkg::OFF_PIN_CFG) begin
        pin_cfg_r <= wdata_i[adcc_pkg::PIN_CFG_W-1:0]; // RULE1
      end else if (addr_i == adcc_pkg::OFF_PORT_DIR) begin
        port_dir_r <= wdata_i[adcc_pkg::PORT_W-1:0];
      end else if (addr_i == adcc_pkg::OFF_IRQ_EN) begin
        irq_en_r <= wdata_i[adcc_pkg::IRQ_DONE_BIT];
      end
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (done) begin
      flag_r <= 1'b1; // RULE3
    end else if (wr_i && (addr_i == adcc_pkg::OFF_IRQ_FLAGS)) begin
      flag_r <= wdata_i[adcc_pkg::IRQ_DONE_BIT];
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adcc_pkg::ADCC_IDLE;
      go_r    <= 1'b0;
    end else begin
      case (state_r)
        adcc_pkg::ADCC_IDLE: begin
          if (start) begin
            state_r <= adcc_pkg::ADCC_CONV;
            go_r    <= 1'b1; // RULE19
          end
        end
        adcc_pkg::ADCC_CONV: begin
          if (abort || done) begin
            state_r <= adcc_pkg::ADCC_IDLE;
            go_r    <= 1'b0; // RULE3
          end
        end
        default: begin
          state_r <= adcc_pkg::ADCC_IDLE;
          go_r    <= 1'b0;
        end
      endcase
    end
  end

  // Comparator high keeps the trial bit, then the next lower bit is tried
  always_comb begin
    trial_nxt = trial_r;
    if (!comp_sync_r) begin // RULE22
      trial_nxt = trial_r & ~mask_r;
    end
    trial_nxt = trial_nxt | (mask_r >> 1);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_r <= 5'h00;
      trial_r    <= 8'h00;
      mask_r     <= 8'h00;
    end else if (start) begin
      half_cnt_r <= 5'h00;
      trial_r    <= adcc_pkg::MSB_MASK;
      mask_r     <= adcc_pkg::MSB_MASK;
    end else if ((state_r == adcc_pkg::ADCC_CONV) && tick) begin
      half_cnt_r <= half_cnt_r + 5'h01; // RULE8
      if (decide) begin
        trial_r <= trial_nxt; // RULE22
        mask_r  <= mask_r >> 1;
      end
    end
  end

  // No reset: contents stay unknown after power-on
  always_ff @(posedge core_clk_i) begin
    if (done) begin
      result_r <= trial_r; // RULE3 RULE4
    end
  end

  // ****************************************
  // Pin decode and registered outputs
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      analog_pins_o    <= adcc_pkg::ANA_MASK_ALL;
      vref_ext_o       <= 1'b0;
      chan_onehot_o    <= 5'h01;
      sample_connect_o <= 1'b1;
      trial_code_o     <= 8'h00;
      converter_on_o   <= 1'b0;
      conv_done_irq_o  <= 1'b0;
      timer_clear_o    <= 1'b0;
    end else begin
      if (pin_cfg_r[2:1] == adcc_pkg::PIN_CFG_DIG) begin // RULE2
        analog_pins_o <= adcc_pkg::ANA_MASK_NONE;
      end else if (pin_cfg_r[2]) begin
        analog_pins_o <= adcc_pkg::ANA_MASK_PART;
      end else begin
        analog_pins_o <= adcc_pkg::ANA_MASK_ALL;
      end
      vref_ext_o <= pin_cfg_r[0] && (pin_cfg_r[2:1] != adcc_pkg::PIN_CFG_DIG); // RULE2
      if (chs_r < 3'(adcc_pkg::CHAN_N)) begin // RULE20
        chan_onehot_o <= 5'h01 << chs_r;
      end else begin
        chan_onehot_o <= 5'h00;
      end
      // Channel routed regardless of pin direction
      sample_connect_o <= !(start || ((state_r == adcc_pkg::ADCC_CONV) && !abort && !done)); // RULE7 RULE14
      trial_code_o     <= start ? adcc_pkg::MSB_MASK : (decide ? trial_nxt : trial_r);
      converter_on_o   <= wr_ctl ? wdata_i[adcc_pkg::CTL_ON_BIT] : on_r;
      conv_done_irq_o  <= flag_r && irq_en_r;
      timer_clear_o    <= trig_hit; // RULE16 RULE17
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == adcc_pkg::OFF_CONTROL) begin
        rdata_o <= {cs_r, chs_r, go_r, 1'b0, on_r}; // RULE19
      end else if (addr_i == adcc_pkg::OFF_RESULT) begin
        rdata_o <= result_r;
      end else if (addr_i == adcc_pkg::OFF_PIN_CFG) begin
        rdata_o <= {5'h00, pin_cfg_r}; // RULE1
      end else if (addr_i == adcc_pkg::OFF_IRQ_FLAGS) begin
        rdata_o <= 8'(flag_r) << adcc_pkg::IRQ_DONE_BIT;
      end else if (addr_i == adcc_pkg::OFF_IRQ_EN) begin
        rdata_o <= 8'(irq_en_r) << adcc_pkg::IRQ_DONE_BIT;
      end else if (addr_i == adcc_pkg::OFF_PORT_DATA) begin
        rdata_o <= {2'h0, pin_sync_r & ~analog_pins_o}; // RULE13
      end else if (addr_i == adcc_pkg::OFF_PORT_DIR) begin
        rdata_o <= {2'h0, port_dir_r};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [12:0] conv_cyc_r;
  logic [3:0]  dec_cnt_r;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_cyc_r <= 13'h0000;
      dec_cnt_r  <= 4'h0;
    end else if (start) begin
      conv_cyc_r <= 13'h0000;
      dec_cnt_r  <= 4'h0;
    end else if (state_r == adcc_pkg::ADCC_CONV) begin
      conv_cyc_r <= conv_cyc_r + 13'h0001;
      if (decide) begin
        dec_cnt_r <= dec_cnt_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_done_seen;
    done ##1 (state_r == adcc_pkg::ADCC_IDLE);
  endsequence

  a_done_loads_result: assert property ( // RULE3
    done |=> (result_r == $past(trial_r)) && !go_r && flag_r)
    else $error("completion did not load result or update flags");

  a_flag_set_wins: assert property ( // RULE3
    (done && wr_i && (addr_i == adcc_pkg::OFF_IRQ_FLAGS)) |=> flag_r)
    else $error("done flag lost to a clear");

  a_conv_length: assert property ( // RULE8
    done |-> (conv_cyc_r == (13'(adcc_pkg::CONV_HALVES) * 13'(load_r)) - 13'h0001))
    else $error("conversion length wrong");

  a_bits_resolved: assert property ( // RULE22
    s_done_seen |-> ($past(dec_cnt_r) == adcc_pkg::RES_BITS))
    else $error("wrong number of bit decisions");

  a_start_disconnect: assert property ( // RULE7
    start |=> !sample_connect_o ##0 go_r)
    else $error("hold stage still connected after start");

  a_trig_start: assert property ( // RULE16
    (trig_hit && on_r && (state_r == adcc_pkg::ADCC_IDLE)) |=> go_r && timer_clear_o)
    else $error("trigger did not start conversion");

  a_trig_off_ignored: assert property ( // RULE17
    (trig_hit && !on_r && !wr_i && (state_r == adcc_pkg::ADCC_IDLE)) |=> !go_r && timer_clear_o)
    else $error("trigger with converter off misbehaved");

  a_go_reads_one: assert property ( // RULE19
    (rd_i && (addr_i == adcc_pkg::OFF_CONTROL) && go_r) |=> rdata_o[adcc_pkg::CTL_GO_BIT])
    else $error("active bit read as zero during conversion");

  a_pin_cfg_read: assert property ( // RULE1
    (rd_i && (addr_i == adcc_pkg::OFF_PIN_CFG)) |=> (rdata_o[7:3] == 5'h00))
    else $error("unimplemented pin config bits read nonzero");

  a_port_analog_zero: assert property ( // RULE13
    (rd_i && (addr_i == adcc_pkg::OFF_PORT_DATA)) |=> ((rdata_o[5:0] & $past(analog_pins_o)) == 6'h00))
    else $error("analog pin read as one");

  a_all_digital: assert property ( // RULE2
    (pin_cfg_r[2:1] == adcc_pkg::PIN_CFG_DIG) |=> (analog_pins_o == 6'h00) && !vref_ext_o)
    else $error("digital code left an analog pin");

  a_chan_decode: assert property ( // RULE20
    ##1 (chan_onehot_o == (($past(chs_r) < 3'h5) ? (5'h01 << $past(chs_r)) : 5'h00)))
    else $error("channel decode wrong");

endmodule : adcc_top

// File: dv/adcc_analog_model.sv
// Behavioural hold stage and comparator on the far side of the converter control.
// Assumes the control block holds the trial code steady for a whole bit period.
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic [7:0] analog_lvl_i,
  input  wire logic [7:0] trial_code_i,
  input  wire logic       sample_connect_i,
  output logic            comp_hi_o
);
  // ****************************************
  // Held sample and instant comparison
  // ****************************************
  logic [7:0] held_r;

  // Sample tracks the pin while connected, holds while converting
  always_latch begin
    if (sample_connect_i) begin
      held_r = analog_lvl_i;
    end
  end

  assign comp_hi_o = (held_r >= trial_code_i);
endmodule : adcc_analog_model

// File: dv/tb_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes a plain one-cycle strobe register port and one 125 MHz clock.
`timescale 1ns/1ps
module tb_adc_conversion_control;
  logic        core_clk_i, rstn_i, wr_i, rd_i, special_trig_i, comp_hi;
  logic [7:0]  addr_i, wdata_i, rdata_o, trial_code_o, analog_lvl, last_res, d;
  logic [5:0]  pin_level_i, analog_pins_o;
  logic [3:0]  compare_mode_sel_i;
  logic [4:0]  chan_onehot_o;
  logic        conv_done_irq_o, timer_clear_o, sample_connect_o, vref_ext_o, converter_on_o;
  int          errors, num_checks;
  logic [7:0]  rst_addr [6] = '{8'h0c, 8'h1f, 8'h8c, 8'h9f, 8'h85, 8'h40};
  logic [7:0]  rst_val  [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00};

  adcc_top dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comp_hi_i(comp_hi),
    .pin_level_i(pin_level_i), .compare_mode_sel_i(compare_mode_sel_i),
    .special_trig_i(special_trig_i), .conv_done_irq_o(conv_done_irq_o),
    .timer_clear_o(timer_clear_o), .sample_connect_o(sample_connect_o),
    .chan_onehot_o(chan_onehot_o), .vref_ext_o(vref_ext_o), .analog_pins_o(analog_pins_o),
    .trial_code_o(trial_code_o), .converter_on_o(converter_on_o));

  adcc_analog_model model (.analog_lvl_i(analog_lvl), .trial_code_i(trial_code_o),
    .sample_connect_i(sample_connect_o), .comp_hi_o(comp_hi));

  // ****************************************
  // Clock, tasks and expectations
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    tick(4);
  endtask : do_reset

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [5:0] exp_mask(input int c);
    return (c >= 6) ? 6'h00 : (c >= 4) ? 6'h0b : 6'h2f;
  endfunction : exp_mask

  function automatic int half_cycles(input int cs);
    return (cs == 3) ? int'(adcc_pkg::HALF_RC) : (2 << (2 * cs)) / 2;
  endfunction : half_cycles

  task automatic conv(input logic [1:0] cs, input logic [2:0] chs, input logic [7:0] val);
    int n;
    int h;
    h = half_cycles(cs);
    analog_lvl <= val;
    wr(8'h1f, {cs, chs, 3'b001});
    wr(8'h0c, 8'h00);
    wr(8'h8c, 8'h40);
    tick(20);
    wr(8'h1f, {cs, chs, 3'b101});
    #1;
    n = 0;
    while (sample_connect_o !== 1'b1 && n < 6000) begin
      n++;
      tick(1);
    end
    chk("conv_cycles", 16'(n), 16'(19 * h));
    tick(1);
    chk("irq", conv_done_irq_o, 1'b1);
    rd(8'h1e, d);
    chk("result", d, val);
    last_res = val;
    rd(8'h1f, d);
    chk("ctrl_done", d, {cs, chs, 3'b001});
    chk("conv_on", converter_on_o, 1'b1);
    rd(8'h0c, d);
    chk("flag", d, 8'h40);
    tick(4 * h);
  endtask : conv

  task automatic trig(input logic [3:0] mode, input logic tc_exp, input logic go_exp);
    compare_mode_sel_i <= mode;
    @(posedge core_clk_i);
    special_trig_i <= 1'b1;
    @(posedge core_clk_i);
    special_trig_i <= 1'b0;
    #1;
    chk("timer_clear", timer_clear_o, tc_exp);
    rd(8'h1f, d);
    chk("trig_go", d[2], go_exp);
    wr(8'h1f, 8'h00);
    tick(4);
  endtask : trig

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
    special_trig_i = 1'b0; compare_mode_sel_i = 4'h0; pin_level_i = 6'h15; analog_lvl = 8'h00;
    errors = 0;
    num_checks = 0;
    void'($urandom(28));
    do_reset();
    for (int i = 0; i < 6; i++) begin
      rd(rst_addr[i], d);
      chk("reset_reg", d, rst_val[i]);
    end
    chk("reset_pins", analog_pins_o, 6'h2f);
    chk("reset_on", converter_on_o, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h9f, {5'h1f, 3'(c)});
      rd(8'h9f, d);
      chk("pin_cfg", d, {5'h00, 3'(c)});
      chk("vref", vref_ext_o, (c == 1 || c == 3 || c == 5));
      chk("analog_pins", analog_pins_o, exp_mask(c));
      pin_level_i <= 6'($urandom);
      tick(4);
      rd(8'h05, d);
      chk("port_data", d, {2'b00, pin_level_i & ~exp_mask(c)});
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h1f, {2'b00, 3'(c), 3'b000});
      tick(2);
      chk("chan", chan_onehot_o, (c < 5) ? 5'(1 << c) : 5'h00);
    end
    wr(8'h0c, 8'h40);
    wr(8'h8c, 8'h00);
    tick(2);
    chk("irq_masked", conv_done_irq_o, 1'b0);
    wr(8'h8c, 8'h40);
    tick(2);
    chk("irq_on", conv_done_irq_o, 1'b1);
    wr(8'h0c, 8'h00);
    tick(2);
    chk("irq_clear", conv_done_irq_o, 1'b0);
    conv(2'h0, 3'h0, 8'h00);
    conv(2'h0, 3'h4, 8'hff);
    for (int cs = 0; cs < 4; cs++) begin
      conv(2'(cs), 3'($urandom_range(4)), 8'($urandom));
    end
    for (int i = 0; i < 3; i++) begin
      conv(2'h1, 3'($urandom_range(4)), 8'($urandom));
    end
    conv(2'h3, 3'h1, 8'ha5);
    // Completion and a flag clear in the same cycle: the set wins
    wr(8'h0c, 8'h00);
    wr(8'h1f, 8'h01);
    wr(8'h1f, 8'h05);
    tick(17);
    wr(8'h0c, 8'h00);
    rd(8'h0c, d);
    chk("flag_race", d, 8'h40);
    last_res = 8'ha5;
    rd(8'h1e, d);
    chk("race_result", d, last_res);
    // Abort mid-conversion by turning the converter off
    wr(8'h0c, 8'h00);
    wr(8'h1f, 8'h45);
    wr(8'h1f, 8'h45);
    rd(8'h1f, d);
    chk("go_busy", d, 8'h45);
    chk("hold_open", sample_connect_o, 1'b0);
    wr(8'h1f, 8'h00);
    tick(100);
    rd(8'h0c, d);
    chk("abort_flag", d, 8'h00);
    rd(8'h1e, d);
    chk("abort_result", d, last_res);
    wr(8'h1f, 8'h05);
    rd(8'h1f, d);
    chk("go_with_on", d, 8'h01);
    trig(4'hb, 1'b1, 1'b1);
    wr(8'h1f, 8'h00);
    trig(4'hb, 1'b1, 1'b0);
    trig(4'ha, 1'b0, 1'b0);
    wr(8'h1f, 8'h45);
    tick(2);
    wr(8'h1f, 8'h45);
    tick(10);
    do_reset();
    rd(8'h1f, d);
    chk("rst_ctrl", d, 8'h00);
    chk("rst_hold", sample_connect_o, 1'b1);
    rd(8'h1e, d);
    chk("rst_result", d, last_res);
    report_and_stop();
  end
endmodule : tb_adc_conversion_control
